// [dv/mode_and_trigger_control_tb_top.sv]
// testbench for the mode and trigger control register
module mode_and_trigger_control_tb_top
	import mtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rst_n = 0, cv = 0, pin = 0, rv, gen, ls, acq, ht, rc, t1, t2, t3, t4;
	logic [15:0] rd;
	mtc_access_t ha;
	int err_total = 0, comparisons = 0, cyc = 0, n;
	always #2.5 mclk = ~mclk;
	mtc_host_model u_mtc_host_model(.mclk(mclk), .host_access(ha));
	// short trigger length keeps the pulse count cheap to walk
	mtc_control #(.TRIG_LENGTH(3)) u_mtc_control(.mclk(mclk), .rst_n(rst_n),
		.host_access(ha), .read_data(rd), .read_valid(rv), .host_cmd_valid(cv),
		.gen_cmd_from_host(gen), .main_list_sel(), .alt_list_sel(), .first_user_input(pin),
		.list_start(ls), .acq_mode(acq), .host_trigger(ht), .register_clear(rc),
		.first_user_output_trig(t1), .second_user_output_trig(t2),
		.delay_gate_trig(t3), .led_trig(t4));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		$display("err_total %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// read and check the answer, which stands in the cycle after the access
	task rdc(input logic [15:0] e);
		u_mtc_host_model.access(1'b0, 4'ha, 16'h0);
		chk({15'h0, rv}, 16'h1);
		chk(rd, e);
	endtask : rdc
	// hang guard: whole run needs well under this many cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 1000) begin
			err_total++;
			final_report;
		end
	end
	initial begin
		repeat (5) @(negedge mclk);
		rst_n = 1;
		rdc(16'h0);
		cv = 1;
		@(negedge mclk) chk(gen, 1);
		u_mtc_host_model.access(1'b1, 4'ha, 16'h1);
		chk({gen, acq}, 16'h1);
		rdc(16'h1);
		u_mtc_host_model.access(1'b1, 4'hb, 16'h0);
		chk(acq, 1);
		pin = 1;
		n = 0;
		while (!ls && n < 8) @(negedge mclk) n++;
		chk(ls, 1);
		u_mtc_host_model.access(1'b1, 4'ha, 16'h3);
		chk({t1, t2, t3, t4}, 16'hf);
		n = 0;
		while (ht && n < 40) @(negedge mclk) n++;
		chk(n[15:0], 16'h3);
		u_mtc_host_model.access(1'b1, 4'ha, 16'h4);
		chk({rc, ht, acq}, 16'h4);
		@(negedge mclk) chk(rc, 0);
		u_mtc_host_model.access(1'b1, 4'ha, 16'h1);
		chk({rc, ht, acq}, 16'h1);
		final_report;
	end
endmodule : mode_and_trigger_control_tb_top

// [dv/mtc_host_model.sv]
// host-side model issuing register accesses over the link
module mtc_host_model
	import mtc_pkg::*;
(
	// clock
	input  wire logic  mclk,
	// access to the block
	output mtc_access_t host_access
);
	timeunit 1ns;
	timeprecision 1ps;
	initial host_access = '0;
	// one access per call, released to an inverted pattern so stale values never match
	task access(input logic w, input logic [3:0] s, input logic [15:0] d);
		@(negedge mclk) host_access <= '{1'b1, w, 4'h1, s, d};
		@(negedge mclk) host_access <= '{1'b0, !w, 4'he, ~s, ~d};
	endtask : access
endmodule : mtc_host_model

// [dv/mtc_sva.sv]
// concurrent checks on the mode and trigger control ports
module mtc_sva
	import mtc_pkg::*;
#(
	parameter int TRIG_LENGTH = 30
) (
	// clock, reset and requests
	input wire logic        mclk,
	input wire logic        rst_n,
	input mtc_access_t      host_access,
	input wire logic        host_cmd_valid,
	// answers
	input wire logic [15:0] read_data,
	input wire logic        read_valid,
	input wire logic        gen_cmd_from_host,
	input wire logic        list_start,
	input wire logic        acq_mode,
	input wire logic        host_trigger,
	input wire logic        register_clear,
	input wire logic        led_trig,
	input wire logic        main_list_sel,
	input wire logic        alt_list_sel
);
	// address decode of the control register
	wire hit = host_access.valid && host_access.primary == 4'h1 && host_access.secondary == 4'ha;
	wire w = hit && host_access.write;
	wire r = hit && !host_access.write;
	wire [15:0] d = host_access.wdata;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_mode_write: assert property (w |=> acq_mode == $past(d[0])) else $error("mode bad");
	a_trig_rise: assert property (w && d[1] |=> host_trigger) else $error("no trigger");
	a_trig_hold: assert property ($rose(host_trigger) |-> host_trigger[*3]) else $error("short");
	a_clear_once: assert property (w && d[2] |=> register_clear ##1 !register_clear)
		else $error("clear pulse bad");
	a_zero_none: assert property (!(w && d[2]) |=> !register_clear) else $error("stray clear");
	a_read_ans: assert property (r |=> read_valid && read_data == {15'h0, acq_mode})
		else $error("read bad");
	a_gen_route: assert property (gen_cmd_from_host == (host_cmd_valid && !acq_mode))
		else $error("route bad");
	a_led_fan: assert property (led_trig == host_trigger) else $error("fan bad");
	// start is registered from the mode one cycle back, so look at that mode
	a_list_mode: assert property (list_start |-> $past(acq_mode)) else $error("start bad");
	a_main_sel: assert property (main_list_sel == (host_access.valid && host_access.primary == 4'h2))
		else $error("main list select bad");
	a_alt_sel: assert property (alt_list_sel == (host_access.valid && host_access.primary == 4'h3))
		else $error("alternate list select bad");
endmodule : mtc_sva
bind mtc_control mtc_sva #(.TRIG_LENGTH(TRIG_LENGTH)) u_mtc_sva(.*);

// [rtl/mtc_control.sv]
// mode and trigger control register, reached by primary and secondary address
`include "mtc_params.svh"
// Overview of operation
// - bit zero selects acquisition or interactive mode
// - interactive mode runs host packets directly
// - acquisition mode runs stored list on trigger
// - writing one to bit one fires trigger
// - host trigger routed to outputs, generators, LEDs
// - writing one to bit two clears registers
// - register accessible while lists still run
// - addresses: control 1/10, lists 2, 3, generator 4
module mtc_control
	import mtc_pkg::*;
#(
	parameter int TRIG_LENGTH = `MTC_TRIG_CYCLES
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// host access
	input  mtc_access_t      host_access,
	output logic [15:0]      read_data,
	output logic             read_valid,
	// command routing from host packets
	input  wire logic        host_cmd_valid,
	output logic             gen_cmd_from_host,
	output logic             main_list_sel,
	output logic             alt_list_sel,
	// acquisition trigger from the first user input pin
	input  wire logic        first_user_input,
	output logic             list_start,
	// mode and strobes
	output logic             acq_mode,
	output logic             host_trigger,
	output logic             register_clear,
	// host trigger fan-out
	output logic             first_user_output_trig,
	output logic             second_user_output_trig,
	output logic             delay_gate_trig,
	output logic             led_trig
);
	initial begin
		if (TRIG_LENGTH < 1) $error("trigger length must be at least one cycle");
	end

	// address decode
	wire hit_ctrl = host_access.valid &&
		host_access.primary == `MTC_PRIMARY_ADDR &&
		host_access.secondary == `MTC_SECONDARY_ADDR;
	wire wr_ctrl = hit_ctrl && host_access.write;
	wire rd_ctrl = hit_ctrl && !host_access.write;
	wire trig_req  = wr_ctrl && host_access.wdata[`MTC_BIT_HOST_TRIG];
	wire clear_req = wr_ctrl && host_access.wdata[`MTC_BIT_CLEAR];

	// pin synchroniser: three stages, a change counts when stages two and three agree
	logic [2:0] in_sync;
	logic       in_level;
	logic       in_level_d;
	mtc_mode_t  mode;

	// mode register; no busy gating so access works mid-list
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode <= MTC_INTERACTIVE;
		end else if (wr_ctrl) begin
			mode <= host_access.wdata[`MTC_BIT_ACQ_MODE] ? MTC_ACQUISITION : MTC_INTERACTIVE;
		end
	end

	// read path and clear strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			read_data      <= `MTC_RESET_VALUE;
			read_valid     <= 1'b0;
			register_clear <= 1'b0;
		end else begin
			read_valid     <= rd_ctrl;
			read_data      <= {15'h0000, mode == MTC_ACQUISITION};
			register_clear <= clear_req;
		end
	end

	// input synchroniser and edge history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			in_sync    <= 3'h0;
			in_level   <= 1'b0;
			in_level_d <= 1'b0;
		end else begin
			in_sync    <= {in_sync[1:0], first_user_input};
			if (in_sync[1] == in_sync[2]) begin
				in_level <= in_sync[2];
			end
			in_level_d <= in_level;
		end
	end

	// list start only on a rising trigger in acquisition mode
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			list_start <= 1'b0;
		end else begin
			list_start <= (mode == MTC_ACQUISITION) && in_level && !in_level_d;
		end
	end

	// host packets feed the generator only in interactive mode
	assign acq_mode          = (mode == MTC_ACQUISITION);
	assign gen_cmd_from_host = host_cmd_valid && !acq_mode;
	assign main_list_sel     = host_access.valid && host_access.primary == `MTC_MAIN_LIST_ADDR;
	assign alt_list_sel      = host_access.valid && host_access.primary == `MTC_ALT_LIST_ADDR;

	mtc_pulse_gen #(
		.LENGTH (TRIG_LENGTH)
	) u_trig (
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (trig_req),
		.pulse (host_trigger)
	);

	// fan-out of the host trigger; selection happens downstream
	assign first_user_output_trig  = host_trigger;
	assign second_user_output_trig = host_trigger;
	assign delay_gate_trig         = host_trigger;
	assign led_trig                = host_trigger;
endmodule : mtc_control

// [rtl/mtc_params.svh]
// constants for the mode and trigger control register block
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
`define MTC_PRIMARY_ADDR      4'h1
`define MTC_SECONDARY_ADDR    4'ha
`define MTC_MAIN_LIST_ADDR    4'h2
`define MTC_ALT_LIST_ADDR     4'h3
`define MTC_CMD_GEN_ADDR      4'h4
`define MTC_REG_WIDTH         16
`define MTC_RESET_VALUE       16'h0000
`define MTC_BIT_ACQ_MODE      0
`define MTC_BIT_HOST_TRIG     1
`define MTC_BIT_CLEAR         2
`define MTC_CLK_PERIOD_NS     5
`define MTC_TRIG_TIME_NS      150
`define MTC_TRIG_CYCLES       ((`MTC_TRIG_TIME_NS + `MTC_CLK_PERIOD_NS - 1) / `MTC_CLK_PERIOD_NS)
`endif

// [rtl/mtc_pkg.sv]
// types shared by the mode and trigger control block
package mtc_pkg;
	typedef enum logic {
		MTC_INTERACTIVE,
		MTC_ACQUISITION
	} mtc_mode_t;

	// one register access from the host link
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  primary;
		logic [3:0]  secondary;
		logic [15:0] wdata;
	} mtc_access_t;
endpackage : mtc_pkg

// [rtl/mtc_pulse_gen.sv]
// fixed-length pulse generator for the host-issued trigger
`include "mtc_params.svh"
module mtc_pulse_gen
	import mtc_pkg::*;
#(
	parameter int LENGTH = `MTC_TRIG_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// start and pulse
	input  wire logic start,
	output logic      pulse
);
	localparam int CW = $clog2(LENGTH + 1);

	initial begin
		if (LENGTH < 1) $error("pulse length must be at least one cycle");
	end

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;

	// a new start restarts the full length rather than extending oddly
	assign next_count = start ? CW'(LENGTH) : (count != '0 ? count - 1'b1 : count);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count <= '0;
			pulse <= 1'b0;
		end else begin
			count <= next_count;
			pulse <= (next_count != '0);
		end
	end
endmodule : mtc_pulse_gen
